// ### hdl/pcs_core.sv
/*
 Program counter, page selection, return stack and indirect data port,
 with the registers on an APB slave.
 Assumes the decoder drives op_in on the core clock and the master
 follows APB signalling; no flow change during a low byte write is needed.
*/
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module pcs_core import pcs_pkg::*; (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire pcs_apb_t apb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire pcs_op_t op_in,
   output logic [PC_W-1:0] pc_out
);

   // ==========================================================
   // Bus decode
   // ==========================================================
   logic pready_r;                    // Answer flag
   logic pready_nxt;
   logic pslverr_r;                   // Unmapped answer
   logic pslverr_nxt;
   logic [31:0] prdata_r;             // Read data
   logic [31:0] prdata_nxt;
   logic ans;                         // Access phase, answer not yet given
   logic wr_fire;                     // Write takes effect this edge
   logic sel_pc_low, sel_lat, sel_ptr, sel_port, sel_dm;
   logic mapped;
   logic [DMEM_IDX_W-1:0] dm_idx;     // Direct window index

   assign ans = apb_in.psel && apb_in.penable && !pready_r;
   assign wr_fire = apb_in.psel && apb_in.penable && pready_r && apb_in.pwrite;
   assign sel_pc_low = apb_in.paddr == OFS_PC_LOW;
   assign sel_lat = apb_in.paddr == OFS_LATCH;
   assign sel_ptr = apb_in.paddr == OFS_PTR;
   assign sel_port = apb_in.paddr == OFS_PORT;
   assign sel_dm = apb_in.paddr[11:9] == OFS_DMEM_TAG;
   assign mapped = sel_pc_low || sel_lat || sel_ptr || sel_port || sel_dm;
   assign dm_idx = apb_in.paddr[8:2];

   // ==========================================================
   // State
   // ==========================================================
   logic [PC_W-1:0] pc_r;             // Program counter
   logic [PC_W-1:0] pc_nxt;
   logic [4:0] latch_r;               // High latch
   logic [4:0] latch_nxt;
   logic [7:0] ptr_r;                 // Indirect pointer
   logic [7:0] ptr_nxt;
   logic [7:0] dmem_r [DMEM_DEPTH];   // Data registers
   logic [7:0] dmem_nxt [DMEM_DEPTH];
   logic [DMEM_IDX_W-1:0] port_idx;   // Register the port points at
   logic port_self;                   // Pointer names the port itself
   logic [PC_W-1:0] page_tgt;         // Paged branch target
   logic [PC_W-1:0] stk_top;          // Most recent return address
   logic push, pop;
   logic [PC_W-1:0] push_d;
   logic pc_low_wr;                   // Low byte write this edge

   assign port_idx = ptr_r[DMEM_IDX_W-1:0];
   assign port_self = port_idx == PORT_SELF;
   assign pc_low_wr = wr_fire && sel_pc_low;
   // Bit twelve stays zero: latch bit four plays no part in paging
   assign page_tgt = {1'b0, latch_r[LATCH_PAGE_BIT], op_in.target};

   // ==========================================================
   // Return stack
   // ==========================================================
   pcs_stack u_stack (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .push_in(push),
      .pop_in(pop),
      .data_in(push_d),
      .top_out(stk_top)
   );

   // ==========================================================
   // Program counter next value
   // ==========================================================
   // Priority: flow change from decoder, then low byte write, then fetch
   always_comb begin
      pc_nxt = pc_r;
      push = 1'b0;
      pop = 1'b0;
      push_d = pc_r;
      case (op_in.kind)
         // Interrupt saves the address not yet executed
         OP_IRQ: begin
            push = 1'b1;
            push_d = pc_r;
            pc_nxt = IRQ_VECTOR;
         end
         // Goto within the selected page
         OP_JUMP: begin
            pc_nxt = page_tgt;
         end
         // Call saves the following address
         OP_CALL: begin
            push = 1'b1;
            push_d = pc_r + PC_STEP;
            pc_nxt = page_tgt;
         end
         // All three returns restore the whole counter
         OP_RET, OP_RET_LIT, OP_RET_INT: begin
            pop = 1'b1;
            pc_nxt = stk_top;
         end
         // No flow change
         default: begin
            if (pc_low_wr) begin
               pc_nxt = {latch_r, apb_in.pwdata[7:0]};
            end else if (op_in.fetch) begin
               pc_nxt = pc_r + PC_STEP;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         pc_r <= PC_RST;
      end else begin
         pc_r <= pc_nxt;
      end
   end

   // ==========================================================
   // Latch and pointer registers
   // ==========================================================
   // Only bus writes touch them; stack traffic never does
   always_comb begin
      latch_nxt = latch_r;
      ptr_nxt = ptr_r;
      if (wr_fire && sel_lat) begin
         latch_nxt = apb_in.pwdata[4:0];
      end
      if (wr_fire && sel_ptr) begin
         ptr_nxt = apb_in.pwdata[7:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         latch_r <= LATCH_RST;
         ptr_r <= PTR_RST;
      end else begin
         latch_r <= latch_nxt;
         ptr_r <= ptr_nxt;
      end
   end

   // ==========================================================
   // Data registers behind the indirect port
   // ==========================================================
   // Port writes land in the pointed entry, never in the port itself
   genvar gi;
   generate
      for (gi = 0; gi < DMEM_DEPTH; gi++) begin : g_dm
         logic hit_dir;   // Direct window write
         logic hit_ind;   // Write through the port
         assign hit_dir = sel_dm && dm_idx == DMEM_IDX_W'(gi);
         assign hit_ind = sel_port && !port_self && port_idx == DMEM_IDX_W'(gi);
         always_comb begin
            dmem_nxt[gi] = dmem_r[gi];
            if (wr_fire && (hit_dir || hit_ind)) begin
               dmem_nxt[gi] = apb_in.pwdata[7:0];
            end
         end
         always_ff @(posedge clk_in) begin
            if (!nrst_in) begin
               dmem_r[gi] <= DMEM_RST;
            end else begin
               dmem_r[gi] <= dmem_nxt[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Bus answer
   // ==========================================================
   // One wait state: answer is prepared the first access cycle
   always_comb begin
      pready_nxt = ans;
      pslverr_nxt = ans && !mapped;
      prdata_nxt = prdata_r;
      if (ans) begin
         prdata_nxt = RD_ZERO;
         if (!apb_in.pwrite) begin
            if (sel_pc_low) begin
               prdata_nxt[7:0] = pc_r[7:0];
            end else if (sel_lat) begin
               prdata_nxt[4:0] = latch_r;
            end else if (sel_ptr) begin
               prdata_nxt[7:0] = ptr_r;
            end else if (sel_port) begin
               prdata_nxt[7:0] = port_self ? PORT_SELF_RD : dmem_r[port_idx];
            end else if (sel_dm) begin
               prdata_nxt[7:0] = dmem_r[dm_idx];
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= RD_ZERO;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata_out = prdata_r;
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;
   assign pc_out = pc_r;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_quiet;
      op_in.kind == OP_NONE;
   endsequence

   sequence s_port_rd;
      ans && !apb_in.pwrite && sel_port;
   endsequence

   property p_pc_low_wr;
      pc_low_wr && op_in.kind == OP_NONE |=> pc_r == {$past(latch_r), $past(apb_in.pwdata[7:0])};
   endproperty
   a_pc_low_wr: assert property (p_pc_low_wr) else $error("low byte write bad counter");

   property p_jump;
      op_in.kind == OP_JUMP |=> pc_r == {1'b0, $past(latch_r[LATCH_PAGE_BIT]), $past(op_in.target)};
   endproperty
   a_jump: assert property (p_jump) else $error("jump target wrong");

   property p_call;
      op_in.kind == OP_CALL |=> stk_top == $past(pc_r) + PC_STEP && pc_r[10:0] == $past(op_in.target);
   endproperty
   a_call: assert property (p_call) else $error("call push wrong");

   property p_irq;
      op_in.kind == OP_IRQ |=> stk_top == $past(pc_r) && pc_r == IRQ_VECTOR;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt push wrong");

   property p_call_ret;
      op_in.kind == OP_CALL ##1 (op_in.kind == OP_NONE && !op_in.fetch && !pc_low_wr) ##1 op_in.kind == OP_RET
         |=> pc_r == $past(pc_r, 3) + PC_STEP;
   endproperty
   a_call_ret: assert property (p_call_ret) else $error("return address lost");

   property p_latch_kept;
      (push || pop) && !(wr_fire && sel_lat) |=> $stable(latch_r);
   endproperty
   a_latch_kept: assert property (p_latch_kept) else $error("stack touched latch");

   property p_fetch;
      s_quiet and (op_in.fetch && !pc_low_wr) |=> pc_r == $past(pc_r) + PC_STEP;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch did not increment");

   property p_self_rd;
      s_port_rd and port_self |=> prdata_out[7:0] == PORT_SELF_RD && pready_out;
   endproperty
   a_self_rd: assert property (p_self_rd) else $error("self read not zero");

   property p_port_rd;
      s_port_rd and !port_self |=> prdata_out[7:0] == $past(dmem_r[port_idx]);
   endproperty
   a_port_rd: assert property (p_port_rd) else $error("port read wrong");

   property p_self_wr;
      wr_fire && sel_port && port_self |=> $stable(dmem_r[PORT_SELF]);
   endproperty
   a_self_wr: assert property (p_self_wr) else $error("self write stored");

endmodule

`default_nettype wire

// ### hdl/pcs_pkg.sv
/*
 Package for the program counter, return stack and indirect port block:
 bus offsets, reset values, field positions, opcode kinds and carriers.
 Assumes a single core clock and a 12-bit APB byte address.
*/
package pcs_pkg;

   // ==========================================================
   // Widths and depths
   // ==========================================================
   localparam int PC_W = 13;           // Program counter width
   localparam int TGT_W = 11;          // Branch target bits in the opcode
   localparam int STK_DEPTH = 8;       // Return stack entries
   localparam int STK_PTR_W = 3;       // Return stack pointer width
   localparam int DMEM_DEPTH = 128;    // Data registers behind the port
   localparam int DMEM_IDX_W = 7;      // Data register index width
   localparam int ADDR_W = 12;         // APB address width

   // ==========================================================
   // Register byte offsets
   // ==========================================================
   localparam logic [ADDR_W-1:0] OFS_PC_LOW = 12'h000; // Program counter low
   localparam logic [ADDR_W-1:0] OFS_LATCH = 12'h004;  // High latch
   localparam logic [ADDR_W-1:0] OFS_PTR = 12'h008;    // Indirect pointer
   localparam logic [ADDR_W-1:0] OFS_PORT = 12'h00C;   // Indirect data port
   localparam logic [2:0] OFS_DMEM_TAG = 3'h1;         // Window 0x200-0x3FC

   // ==========================================================
   // Reset values and constants
   // ==========================================================
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;      // Program counter
   localparam logic [PC_W-1:0] PC_STEP = 13'h0001;     // Fetch increment
   localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;  // Interrupt target
   localparam logic [4:0] LATCH_RST = 5'h00;           // High latch
   localparam logic [7:0] PTR_RST = 8'h00;             // Indirect pointer
   localparam logic [7:0] DMEM_RST = 8'h00;            // Data registers
   localparam logic [PC_W-1:0] STK_RST = 13'h0000;     // Stack entries
   localparam logic [STK_PTR_W-1:0] SPTR_RST = 3'h0;   // Stack pointer
   localparam logic [STK_PTR_W-1:0] SPTR_STEP = 3'h1;  // Stack step
   localparam logic [DMEM_IDX_W-1:0] PORT_SELF = 7'h00; // Port's own index
   localparam logic [7:0] PORT_SELF_RD = 8'h00;        // Self-read value
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;    // Read data at reset, base of each answer

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int LATCH_PAGE_BIT = 3;  // Page select used by branches
   localparam int LATCH_IGN_BIT = 4;   // Stored, unused for paging

   // ==========================================================
   // Opcode kinds from the decoder
   // ==========================================================
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_JUMP = 3'b001,
      OP_CALL = 3'b010,
      OP_RET = 3'b011,
      OP_RET_LIT = 3'b100,
      OP_RET_INT = 3'b101,
      OP_IRQ = 3'b110
   } pcs_opk_t;

   // Decoder request
   typedef struct packed {
      logic fetch;                     // An instruction was fetched
      pcs_opk_t kind;                  // Flow change kind
      logic [TGT_W-1:0] target;        // Branch target low bits
   } pcs_op_t;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } pcs_apb_t;

endpackage

// ### hdl/pcs_stack.sv
/*
 Circular return-address stack, eight entries of thirteen bits.
 Assumes push and pop are never asked in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module pcs_stack import pcs_pkg::*; (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [PC_W-1:0] data_in,
   output logic [PC_W-1:0] top_out
);

   // ==========================================================
   // Storage
   // ==========================================================
   logic [PC_W-1:0] ent_r [STK_DEPTH];     // Entries
   logic [PC_W-1:0] ent_nxt [STK_DEPTH];   // Entry next values
   logic [STK_PTR_W-1:0] ptr_r;            // Next free slot, hidden
   logic [STK_PTR_W-1:0] ptr_nxt;
   logic [STK_PTR_W-1:0] top_idx;          // Most recent slot

   // Pointer wraps freely, no overflow flag
   always_comb begin
      ptr_nxt = ptr_r;
      if (push_in) begin
         ptr_nxt = ptr_r + SPTR_STEP;
      end else if (pop_in) begin
         ptr_nxt = ptr_r - SPTR_STEP;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ptr_r <= SPTR_RST;
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   // One slot per entry; a push overwrites whatever the slot held
   genvar gi;
   generate
      for (gi = 0; gi < STK_DEPTH; gi++) begin : g_ent
         always_comb begin
            ent_nxt[gi] = ent_r[gi];
            if (push_in && ptr_r == STK_PTR_W'(gi)) begin
               ent_nxt[gi] = data_in;
            end
         end
         always_ff @(posedge clk_in) begin
            if (!nrst_in) begin
               ent_r[gi] <= STK_RST;
            end else begin
               ent_r[gi] <= ent_nxt[gi];
            end
         end
      end
   endgenerate

   // Top of stack for returns
   assign top_idx = ptr_r - SPTR_STEP;
   assign top_out = ent_r[top_idx];

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_push;
      push_in && !pop_in;
   endsequence

   property p_wrap;
      s_push |=> ptr_r == STK_PTR_W'($past(ptr_r) + SPTR_STEP) && top_out == $past(data_in);
   endproperty
   a_wrap: assert property (p_wrap) else $error("stack push did not advance");

   property p_pop_back;
      s_push ##1 (!push_in && !pop_in) ##1 (pop_in && !push_in) |=> top_out == $past(top_out, 3);
   endproperty
   a_pop_back: assert property (p_pop_back) else $error("stack pop lost entry");

endmodule

`default_nettype wire

// ### verif/pcs_dec_model.sv
/*
 Decoder model: drives one flow-change request per two cycles.
 Assumes the core samples op_in on every rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module pcs_dec_model import pcs_pkg::*; (
   input wire logic clk_in,
   output pcs_op_t op_out,
   output logic chk_out
);
   // ==========================================================
   // Idle request
   // ==========================================================
   // Start idle with no result pending
   initial begin
      op_out = '0;
      chk_out = 1'b0;
   end

   // ==========================================================
   // Request driver
   // ==========================================================
   // One edge of request, then idle with the target scrambled
   task automatic send(input pcs_opk_t k, input logic f, input logic [TGT_W-1:0] t);
      op_out <= '{fetch: f, kind: k, target: t};
      @(posedge clk_in);
      op_out <= '{fetch: 1'b0, kind: OP_NONE, target: ~t};
      chk_out <= 1'b1;
      @(posedge clk_in);
      chk_out <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ### verif/pcs_core_bench.sv
/*
 Self-checking bench for the counter, stack and indirect port block.
 Assumes the APB slave answers after one wait state and pc_out moves
 at the edge that takes a request.
*/
`timescale 1ns/1ns
`default_nettype none

module pcs_core_bench import pcs_pkg::*;;
   // ==========================================================
   // Signals and reference state
   // ==========================================================
   typedef struct packed {logic rd; logic err; logic [31:0] d;} pcs_exp_t;
   logic clk_in = 1'b0;             // Core clock
   logic nrst_in = 1'b0;            // Reset, active low
   pcs_apb_t apb_req = '0;          // APB master request
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   pcs_op_t op;                     // Decoder request
   logic chk;                       // A pc result is due
   logic [PC_W-1:0] pc;
   pcs_exp_t aq[$];                 // Pending bus answers
   logic [PC_W-1:0] pq[$];          // Pending pc values
   logic [PC_W-1:0] mpc;            // Reference counter
   logic [PC_W-1:0] mstk[STK_DEPTH];
   logic [STK_PTR_W-1:0] msp;
   logic [4:0] mlat;                // Reference high latch
   int err_count = 0;
   int n_compared = 0;

   always #50 clk_in = ~clk_in;

   pcs_core u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .apb_in(apb_req), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .op_in(op), .pc_out(pc));
   pcs_dec_model u_dec (.clk_in(clk_in), .op_out(op), .chk_out(chk));

   // ==========================================================
   // Comparison and closing
   // ==========================================================
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t pc=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==========================================================
   // Drivers
   // ==========================================================
   // One APB transfer; the answer is noted for the monitor
   task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                           input logic [31:0] e, input logic err);
      int n;
      aq.push_back('{rd: !wr, err: err, d: e});
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk_in);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
      end
      // Release; data bus no longer shows the old word
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      apb_req.pwdata <= ~d;
      @(posedge clk_in);
   endtask

   // Latch write also updates the reference
   task automatic wlat(input logic [4:0] v);
      apb_xfer(1'b1, OFS_LATCH, {27'h0, v}, 32'h0, 1'b0);
      mlat = v;
   endtask

   // Flow request with the pc it should leave behind
   task automatic op_go(input pcs_opk_t k, input logic f, input logic [TGT_W-1:0] t);
      case (k)
         OP_JUMP: mpc = {1'b0, mlat[3], t};
         OP_CALL: begin
            mstk[msp] = mpc + PC_STEP;
            msp = msp + SPTR_STEP;
            mpc = {1'b0, mlat[3], t};
         end
         OP_IRQ: begin
            mstk[msp] = mpc;
            msp = msp + SPTR_STEP;
            mpc = IRQ_VECTOR;
         end
         OP_RET, OP_RET_LIT, OP_RET_INT: begin
            msp = msp - SPTR_STEP;
            mpc = mstk[msp];
         end
         default: if (f) mpc = mpc + PC_STEP;
      endcase
      pq.push_back(mpc);
      u_dec.send(k, f, t);
   endtask

   // ==========================================================
   // Monitors
   // ==========================================================
   // Bus answer checked at the edge that completes the transfer
   always @(posedge clk_in) begin : mon_apb
      pcs_exp_t e;
      if (apb_req.psel && apb_req.penable && pready === 1'b1) begin
         e = aq.pop_front();
         if (e.rd) begin
            cmp32(prdata, e.d);
         end
         cmp32({31'h0, pslverr}, {31'h0, e.err});
      end
   end

   // Counter checked once the taking edge has settled
   always @(negedge clk_in) begin
      if (chk === 1'b1) begin
         cmp_pc(pc, pq.pop_front());
      end
   end

   // ==========================================================
   // Watchdog
   // ==========================================================
   initial begin
      #(100 * 20000);
      err_count++;
      final_report();
   end

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin : main
      int i;
      logic [7:0] v;
      logic [6:0] p;
      pcs_opk_t rk[3];
      rk = '{OP_RET, OP_RET_LIT, OP_RET_INT};
      void'($urandom(32'h0092d232));
      mpc = PC_RST;
      msp = SPTR_RST;
      mlat = LATCH_RST;
      repeat (4) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      // Reset values
      apb_xfer(1'b0, OFS_PC_LOW, 32'h0, 32'h0, 1'b0);
      apb_xfer(1'b0, OFS_LATCH, 32'h0, 32'h0, 1'b0);
      apb_xfer(1'b0, OFS_PTR, 32'h0, 32'h0, 1'b0);
      op_go(OP_NONE, 1'b0, 11'h0);
      for (i = 0; i < 5; i++) op_go(OP_NONE, 1'b1, 11'h0);
      // Every page-bit pair, bit four set and clear
      for (i = 0; i < 4; i++) begin
         wlat({i[1], i[0], 3'($urandom)});
         op_go(OP_JUMP, 1'b0, 11'($urandom));
         op_go(OP_CALL, 1'b0, 11'($urandom));
         op_go(rk[i % 3], 1'b0, 11'($urandom));
         apb_xfer(1'b0, OFS_LATCH, 32'h0, {27'h0, mlat}, 1'b0);
      end
      // Low byte write loads the upper bits from the latch
      wlat(5'($urandom));
      v = 8'($urandom);
      apb_xfer(1'b1, OFS_PC_LOW, {24'h0, v}, 32'h0, 1'b0);
      mpc = {mlat, v};
      op_go(OP_NONE, 1'b0, 11'h0);
      apb_xfer(1'b0, OFS_PC_LOW, 32'h0, {24'h0, v}, 1'b0);
      op_go(OP_NONE, 1'b1, 11'h0);
      // Nine pushes wrap the stack, nine pops follow
      for (i = 0; i < 9; i++) begin
         if (i == 4) op_go(OP_IRQ, 1'b0, 11'h0);
         else op_go(OP_CALL, 1'b0, 11'($urandom));
      end
      for (i = 0; i < 9; i++) op_go(rk[i % 3], 1'b0, 11'h0);
      apb_xfer(1'b0, OFS_LATCH, 32'h0, {27'h0, mlat}, 1'b0);
      // Indirect port reaches the pointed register
      apb_xfer(1'b1, 12'h200, 32'h5A, 32'h0, 1'b0);
      for (i = 0; i < 4; i++) begin
         p = 7'(1 + $urandom % 127);
         v = 8'($urandom);
         apb_xfer(1'b1, OFS_PTR, {25'h0, p}, 32'h0, 1'b0);
         apb_xfer(1'b0, OFS_PTR, 32'h0, {25'h0, p}, 1'b0);
         apb_xfer(1'b1, OFS_PORT, {24'h0, v}, 32'h0, 1'b0);
         apb_xfer(1'b0, 12'h200 + {3'h0, p, 2'b00}, 32'h0, {24'h0, v}, 1'b0);
         apb_xfer(1'b0, OFS_PORT, 32'h0, {24'h0, v}, 1'b0);
      end
      // Port aimed at itself reads zero and stores nothing
      apb_xfer(1'b1, OFS_PTR, 32'h0, 32'h0, 1'b0);
      apb_xfer(1'b0, OFS_PORT, 32'h0, {24'h0, PORT_SELF_RD}, 1'b0);
      apb_xfer(1'b1, OFS_PORT, 32'hA5, 32'h0, 1'b0);
      apb_xfer(1'b0, 12'h200, 32'h0, 32'h5A, 1'b0);
      apb_xfer(1'b1, OFS_PTR, 32'h80, 32'h0, 1'b0);
      apb_xfer(1'b0, OFS_PORT, 32'h0, 32'h0, 1'b0);
      // Unmapped places are refused
      apb_xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      apb_xfer(1'b1, 12'h014, 32'hFF, 32'h0, 1'b1);
      repeat (2) @(posedge clk_in);
      final_report();
   end
endmodule

`default_nettype wire
